// file: design/sarcc_top.sv
// Successive-approximation converter control with APB register access.
// Assumes comparator, sleep, strap and oscillator arrive asynchronously.
// Operation
// - Ten-bit result by successive approximation, bitwise.
// - Result right-justified over high and low bytes.
// - All sources share one mux and hold.
// - Five-bit field picks the multiplexer source.
// - Channel ten is the die temperature tap.
// - Nineteen or twenty-one sources by package variant.
// - Three-bit select picks divided or RC clock.
// - RC clock is oscillator divided by sixteen.
// - Conversion lasts eleven conversion clock periods.
// - Divided clocks follow system clock frequency changes.
// - Sleep conversions continue only with RC clock.
// - Done flag sets on every conversion end.
// - Request needs done flag and its enable.
// - Enabled completion wakes the sleeping device.
// - Vector to handler only with global enables.
// - Power bit enables; start bit begins conversion.
// - Completion clears start, sets flag, loads result.
// - Software abort keeps result, two-period restart delay.
`timescale 1ns/1ps
`include "sarcc_params.svh"
module sarcc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Analog and core side
    input wire logic comp_i,
    input wire logic rc_osc_i,
    input wire logic sleep_i,
    input wire logic pkg_large_i,
    output logic [9:0] sar_code_o,
    output logic [4:0] mux_sel_o,
    output logic mux_valid_o,
    output logic temp_sel_o,
    output logic hold_o,
    output logic conv_irq_o,
    output logic wake_o,
    output logic vector_o
);

    // Two-stage synchronisers for comparator, oscillator, sleep and strap
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    wire [3:0] async_in = {pkg_large_i, sleep_i, rc_osc_i, comp_i};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate
    wire comp_s = sync2_r[0];
    wire rc_s = sync2_r[1];
    wire sleep_s = sync2_r[2];
    wire strap_s = sync2_r[3];

    // Software-visible state
    logic pwr_r;                 // converter_power_on
    logic busy_r;                // Start/busy bit
    logic [4:0] chs_r;           // channel_select
    logic [2:0] cs_r;            // conv_clock_select
    logic flag_r;                // conv_done_flag
    logic ie_r;                  // conv_done_irq_enable
    logic peripheral_irq_enable_r;                // peripheral_irq_enable
    logic gie_r;                 // global_irq_enable
    logic [9:0] res_r;           // Last complete result
    // Sequencer state
    sarcc_pkg::sarcc_state_t st_r;
    sarcc_pkg::sarcc_state_t st_nxt;
    logic [9:0] sar_r;           // Trial code presented to the DAC
    logic [9:0] mask_r;          // Bit under test, one-hot
    logic [1:0] abrt_cnt_r;      // Periods spent in the abort delay
    logic rc_d_r;                // Previous synchronised oscillator level
    logic large_r;               // Package variant caught after reset
    logic [1:0] strap_cnt_r;     // Edges since release, until the strap is caught
    // APB answer registers
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    // Registered pin outputs
    logic irq_r;
    logic wake_r;
    logic vec_r;
    logic mux_valid_r;
    logic temp_sel_r;
    logic hold_r;                // Hold capacitor disconnected

    // Conversion clock generator
    sarcc_tad_if tad_if ();
    sarcc_tad_gen u_tad (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tad(tad_if)
    );
    wire rc_edge = rc_s && !rc_d_r;
    wire tick = tad_if.tick;
    assign tad_if.csel = cs_r;
    assign tad_if.rc_edge = rc_edge;

    // APB decode: access phase with our answer ready commits the transfer
    wire apb_acc = psel_i && penable_i;
    wire apb_commit = apb_acc && pready_r;
    wire hit_c0 = (paddr_i == `SARCC_OFF_CTRL0);
    wire hit_c1 = (paddr_i == `SARCC_OFF_CTRL1);
    wire hit_fl = (paddr_i == `SARCC_OFF_FLAG);
    wire hit_ie = (paddr_i == `SARCC_OFF_IEN);
    wire hit_rh = (paddr_i == `SARCC_OFF_RESH);
    wire hit_rl = (paddr_i == `SARCC_OFF_RESL);
    wire hit_any = hit_c0 || hit_c1 || hit_fl || hit_ie || hit_rh || hit_rl;
    wire wr_ok = apb_commit && pwrite_i && hit_any;
    wire wr_c0 = wr_ok && hit_c0;
    wire wr_c1 = wr_ok && hit_c1;
    wire wr_fl = wr_ok && hit_fl;
    wire wr_ie = wr_ok && hit_ie;
    wire wd_go = pwdata_i[`SARCC_C0_GO_BIT];
    wire wd_pwr = pwdata_i[`SARCC_C0_PWR_BIT];

    // Read multiplexer; unused bits read as zero
    wire [31:0] rd_c0 = {25'h0000000, chs_r, busy_r, pwr_r};
    wire [31:0] rd_c1 = {29'h00000000, cs_r};
    wire [31:0] rd_fl = {31'h00000000, flag_r};
    wire [31:0] rd_ie = {29'h00000000, gie_r, peripheral_irq_enable_r, ie_r};
    wire [31:0] rd_rh = {30'h00000000, res_r[9:8]};
    wire [31:0] rd_rl = {24'h000000, res_r[7:0]};
    wire [31:0] rd_mux = hit_c0 ? rd_c0 : hit_c1 ? rd_c1 : hit_fl ? rd_fl :
                         hit_ie ? rd_ie : hit_rh ? rd_rh : hit_rl ? rd_rl : 32'h00000000;

    // Start needs the converter already powered and the sequencer acquiring
    wire go_set = wr_c0 && wd_go && pwr_r && (st_r == sarcc_pkg::SARCC_ST_ACQ);
    wire sw_abort = wr_c0 && !wd_go && busy_r;
    // Generator restarts on a software abort so the delay is two whole periods
    assign tad_if.run = (busy_r && !sw_abort) || (st_r == sarcc_pkg::SARCC_ST_ABRT);
    wire pwr_off = wr_c0 && !wd_pwr;
    // Sleep stops a conversion unless it runs from the oscillator
    wire rc_clk = (cs_r[1:0] == 2'b11);
    wire sleep_abort = sleep_s && !rc_clk && busy_r;
    wire last_bit = (st_r == sarcc_pkg::SARCC_ST_BITS) && tick && mask_r[0];
    wire done = last_bit && busy_r && !sw_abort && !pwr_off && !sleep_abort;
    wire [9:0] sar_kept = comp_s ? sar_r : (sar_r & ~mask_r);
    wire ch_limit_ok = large_r ? (chs_r < `SARCC_CH_COUNT_LARGE) : (chs_r < `SARCC_CH_COUNT_SMALL);

    // Sequencer next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            sarcc_pkg::SARCC_ST_ACQ: begin
                if (busy_r) begin
                    st_nxt = sarcc_pkg::SARCC_ST_HOLD;
                end
            end
            sarcc_pkg::SARCC_ST_HOLD: begin
                if (tick) begin
                    st_nxt = sarcc_pkg::SARCC_ST_BITS;
                end
            end
            sarcc_pkg::SARCC_ST_BITS: begin
                if (done) begin
                    st_nxt = sarcc_pkg::SARCC_ST_ACQ;
                end
            end
            sarcc_pkg::SARCC_ST_ABRT: begin
                if (tick && (abrt_cnt_r == `SARCC_ABORT_LAST)) begin
                    st_nxt = sarcc_pkg::SARCC_ST_ACQ;
                end
            end
            default: begin
                st_nxt = sarcc_pkg::SARCC_ST_ACQ;
            end
        endcase
        // Power off or sleep drops straight back; software abort waits two periods
        if (pwr_off || sleep_abort) begin
            st_nxt = sarcc_pkg::SARCC_ST_ACQ;
        end else if (sw_abort) begin
            st_nxt = sarcc_pkg::SARCC_ST_ABRT;
        end
    end

    // Sequencer state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= sarcc_pkg::SARCC_ST_ACQ;
            hold_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            // Registered from the next state so the pin keeps the state timing
            hold_r <= (st_nxt != sarcc_pkg::SARCC_ST_ACQ);
        end
    end

    // Abort delay period counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            abrt_cnt_r <= 2'h0;
        end else if (st_r != sarcc_pkg::SARCC_ST_ABRT) begin
            abrt_cnt_r <= 2'h0;
        end else if (tick) begin
            abrt_cnt_r <= abrt_cnt_r + 2'h1;
        end
    end

    // Trial code: top bit first after the hold period, keep or drop on compare
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sar_r <= `SARCC_RST_RES;
            mask_r <= 10'h000;
        end else if (st_r == sarcc_pkg::SARCC_ST_HOLD && tick) begin
            sar_r <= 10'h200;
            mask_r <= 10'h200;
        end else if (st_r == sarcc_pkg::SARCC_ST_BITS && tick) begin
            sar_r <= sar_kept | (mask_r >> 1);
            mask_r <= mask_r >> 1;
        end
    end

    // Result only loads on a clean completion, never on an abort
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            res_r <= `SARCC_RST_RES;
        end else if (done) begin
            res_r <= sar_kept;
        end
    end

    // Power, start/busy and channel bits
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_r <= 1'b0;
            busy_r <= 1'b0;
            chs_r <= `SARCC_RST_CHS;
        end else begin
            if (wr_c0) begin
                pwr_r <= wd_pwr;
                chs_r <= pwdata_i[`SARCC_C0_CHS_MSB:`SARCC_C0_CHS_LSB];
            end
            // Start wins over completion; sleep leaves the power bit set
            if (go_set) begin
                busy_r <= 1'b1;
            end else if (done || sw_abort || pwr_off || sleep_abort) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Clock select and enables
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_r <= `SARCC_RST_CS;
            ie_r <= 1'b0;
            peripheral_irq_enable_r <= 1'b0;
            gie_r <= 1'b0;
        end else begin
            if (wr_c1) begin
                cs_r <= pwdata_i[`SARCC_C1_CS_MSB:`SARCC_C1_CS_LSB];
            end
            if (wr_ie) begin
                ie_r <= pwdata_i[`SARCC_IEN_DONE_BIT];
                peripheral_irq_enable_r <= pwdata_i[`SARCC_IEN_PERI_BIT];
                gie_r <= pwdata_i[`SARCC_IEN_GLOB_BIT];
            end
        end
    end

    // Done flag: set on every completion, cleared only by a write of one
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_r <= 1'b0;
        end else if (done) begin
            flag_r <= 1'b1;
        end else if (wr_fl && pwdata_i[`SARCC_FLAG_DONE_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    // Oscillator edge history and package strap caught after reset release
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rc_d_r <= 1'b0;
            large_r <= 1'b0;
            strap_cnt_r <= 2'h0;
        end else begin
            rc_d_r <= rc_s;
            if (strap_cnt_r != 2'h3) begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
            // Synchroniser holds its reset value for two edges; catch the third
            if (strap_cnt_r == 2'h2) begin
                large_r <= strap_s;
            end
        end
    end

    // Mux steering: one source to the single hold stage, temperature on channel ten
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mux_valid_r <= 1'b0;
            temp_sel_r <= 1'b0;
        end else begin
            mux_valid_r <= ch_limit_ok;
            temp_sel_r <= (chs_r == `SARCC_CH_TEMP);
        end
    end

    // Interrupt request, wake and vector, all from registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
            wake_r <= 1'b0;
            vec_r <= 1'b0;
        end else begin
            irq_r <= flag_r && ie_r;
            wake_r <= flag_r && ie_r && sleep_s;
            vec_r <= flag_r && ie_r && peripheral_irq_enable_r && gie_r;
        end
    end

    // APB answer: one wait state, error on unmapped address
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else if (apb_acc && !pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= !hit_any;
            prdata_r <= pwrite_i ? 32'h00000000 : rd_mux;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign sar_code_o = sar_r;
    assign mux_sel_o = chs_r;
    assign mux_valid_o = mux_valid_r;
    assign temp_sel_o = temp_sel_r;
    // Hold capacitor is disconnected from hold through the abort delay
    assign hold_o = hold_r;
    assign conv_irq_o = irq_r;
    assign wake_o = wake_r;
    assign vector_o = vec_r;

endmodule

// file: design/sarcc_params.svh
// Constants of the converter control block: register offsets, field positions,
// reset values and conversion timing counts.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef SARCC_PARAMS_SVH
`define SARCC_PARAMS_SVH

// Register byte offsets on the APB slave
`define SARCC_OFF_CTRL0 12'h000
`define SARCC_OFF_CTRL1 12'h004
`define SARCC_OFF_FLAG 12'h008
`define SARCC_OFF_IEN 12'h00c
`define SARCC_OFF_RESH 12'h010
`define SARCC_OFF_RESL 12'h014

// Control register 0 fields
`define SARCC_C0_PWR_BIT 0
`define SARCC_C0_GO_BIT 1
`define SARCC_C0_CHS_LSB 2
`define SARCC_C0_CHS_MSB 6

// Control register 1, flag and enable fields
`define SARCC_C1_CS_LSB 0
`define SARCC_C1_CS_MSB 2
`define SARCC_FLAG_DONE_BIT 0
`define SARCC_IEN_DONE_BIT 0
`define SARCC_IEN_PERI_BIT 1
`define SARCC_IEN_GLOB_BIT 2

// Reset values
`define SARCC_RST_CHS 5'h00
`define SARCC_RST_CS 3'h0
`define SARCC_RST_RES 10'h000

// Channel map
`define SARCC_CH_TEMP 5'h0a
`define SARCC_CH_COUNT_SMALL 5'h13
`define SARCC_CH_COUNT_LARGE 5'h15

// Conversion clock divisors, as terminal counts of the 6-bit system and 4-bit oscillator counters
`define SARCC_DIV8_LAST 6'h07
`define SARCC_DIV16_LAST 6'h0f
`define SARCC_DIV32_LAST 6'h1f
`define SARCC_DIV64_LAST 6'h3f
`define SARCC_RC_DIV_LAST 4'hf

// Conversion periods: one hold period plus ten bit periods, then abort delay
`define SARCC_CONV_PERIODS 4'hb
`define SARCC_ABORT_LAST 2'h1

`endif

// file: design/sarcc_pkg.sv
// Types shared by the converter control block and its clock generator.
// Assumes the params header carries all numeric constants.
package sarcc_pkg;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        SARCC_ST_ACQ = 2'b00,
        SARCC_ST_HOLD = 2'b01,
        SARCC_ST_BITS = 2'b10,
        SARCC_ST_ABRT = 2'b11
    } sarcc_state_t;

    // Conversion clock select codes
    typedef enum logic [2:0] {
        SARCC_CS_OFF0 = 3'b000,
        SARCC_CS_DIV8 = 3'b001,
        SARCC_CS_DIV32 = 3'b010,
        SARCC_CS_RC0 = 3'b011,
        SARCC_CS_OFF4 = 3'b100,
        SARCC_CS_DIV16 = 3'b101,
        SARCC_CS_DIV64 = 3'b110,
        SARCC_CS_RC1 = 3'b111
    } sarcc_csel_t;

endpackage

// file: design/sarcc_tad_if.sv
// Link between the sequencer and the conversion clock generator.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
interface sarcc_tad_if;
    logic [2:0] csel;    // Conversion clock select code
    logic run;           // Generator counts while high, restarts when low
    logic rc_edge;       // One-cycle pulse per synchronised oscillator rising edge
    logic tick;          // One-cycle pulse at the end of each conversion period

    modport seq (output csel, output run, output rc_edge, input tick);
    modport gen (input csel, input run, input rc_edge, output tick);
endinterface

// file: design/sarcc_tad_gen.sv
// Conversion clock generator: divides the system clock or counts oscillator edges.
// Assumes csel is stable while run is high; rc_edge already synchronised.
`timescale 1ns/1ps
`include "sarcc_params.svh"
module sarcc_tad_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    sarcc_tad_if.gen tad
);

    logic [5:0] sys_cnt_r;    // System clock period counter
    logic [3:0] rc_cnt_r;     // Oscillator edge counter
    logic tick_r;             // Registered period end pulse

    wire rc_sel = (tad.csel[1:0] == 2'b11);
    // Terminal count per divided option; codes 000 and 100 give no clock at all
    wire [5:0] sys_last = (tad.csel == sarcc_pkg::SARCC_CS_DIV8) ? `SARCC_DIV8_LAST :
                          (tad.csel == sarcc_pkg::SARCC_CS_DIV16) ? `SARCC_DIV16_LAST :
                          (tad.csel == sarcc_pkg::SARCC_CS_DIV32) ? `SARCC_DIV32_LAST :
                          `SARCC_DIV64_LAST;
    wire sys_valid = !rc_sel && (tad.csel[1:0] != 2'b00);
    wire sys_end = sys_valid && (sys_cnt_r == sys_last);
    wire rc_end = rc_sel && tad.rc_edge && (rc_cnt_r == `SARCC_RC_DIV_LAST);

    // Divided system clock tracks any system clock change by construction
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_cnt_r <= 6'h00;
        end else if (!tad.run || sys_end) begin
            sys_cnt_r <= 6'h00;
        end else if (sys_valid) begin
            sys_cnt_r <= sys_cnt_r + 6'h01;
        end
    end

    // Oscillator divided by sixteen, independent of the system divider
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rc_cnt_r <= 4'h0;
        end else if (!tad.run) begin
            rc_cnt_r <= 4'h0;
        end else if (rc_sel && tad.rc_edge) begin
            rc_cnt_r <= rc_cnt_r + 4'h1;
        end
    end

    // One pulse per conversion period
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= tad.run && (sys_end || rc_end);
        end
    end

    assign tad.tick = tick_r;

endmodule

// file: sim/sarcc_checker.sv
// Port-level checker for the converter control top.
// Assumes the package strap, for 19 or 21 sources, is settled within a few edges of reset release.
`timescale 1ns/1ps
module sarcc_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pkg_large_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [4:0] mux_sel_o,
    input wire logic mux_valid_o,
    input wire logic temp_sel_o,
    input wire logic hold_o,
    input wire logic conv_irq_o,
    input wire logic wake_o,
    input wire logic vector_o
);
    logic [2:0] up_r; // Edges since reset, so decode checks skip the strap capture
    logic up_ok;
    assign up_ok = (up_r == 3'h7);

    // Saturating age counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_r <= 3'h0;
        end else if (!up_ok) begin
            up_r <= up_r + 3'h1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_APB_WAIT: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("bus answer missing after one wait state");
    AST_ERR_PAIR: assert property (pslverr_o |-> pready_o)
        else $error("error pulse without ready");
    AST_HOLD_MIN: assert property ($rose(hold_o) |-> hold_o [*8])
        else $error("hold shorter than one period");
    AST_WAKE: assert property (wake_o |-> conv_irq_o)
        else $error("wake without enabled completion");
    AST_VECTOR: assert property (vector_o |-> conv_irq_o)
        else $error("vector without enabled completion");
    AST_TEMP: assert property (up_ok && $stable(mux_sel_o) |-> temp_sel_o == (mux_sel_o == 5'h0a))
        else $error("temperature select decode wrong");
    AST_VALID: assert property (up_ok && $stable(mux_sel_o) |->
        mux_valid_o == (mux_sel_o < (pkg_large_i ? 5'h15 : 5'h13)))
        else $error("channel valid decode wrong");
    AST_RESET: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |-> !hold_o && !conv_irq_o && mux_sel_o == 5'h00)
        else $error("outputs not cleared in reset");
endmodule

bind sarcc_top sarcc_checker u_chk (.clk_i, .rst_i, .psel_i, .penable_i, .pkg_large_i, .pready_o,
    .pslverr_o, .mux_sel_o, .mux_valid_o, .temp_sel_o, .hold_o, .conv_irq_o, .wake_o, .vector_o);

// file: sim/sar_adc_conversion_control_tb.sv
// Self-checking bench for the converter control top.
// Assumes the params header is on the include path; comparator is modelled here.
`timescale 1ns/1ps
`include "sarcc_params.svh"
module sar_adc_conversion_control_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b0; // Raised at time zero so the asynchronous reset sees an edge
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic comp_i = 1'b0;
    logic rc_osc_i = 1'b0;
    logic sleep_i = 1'b0;
    logic pkg_large_i = 1'b0; // Small variant strap
    logic [31:0] prdata_o;
    logic [31:0] q; // Last read data
    logic pready_o, pslverr_o, mux_valid_o, temp_sel_o, hold_o, conv_irq_o, wake_o, vector_o;
    logic err;
    logic [9:0] sar_code_o;
    logic [4:0] mux_sel_o;
    int fail_count = 0;
    int checked = 0;
    int hcnt = 0; // Cycles with hold high
    int ain = 0; // Analog input as a code
    int res_exp = 0; // Result the registers should hold
    int codes[6] = '{1, 5, 2, 6, 3, 7};
    int divs[6] = '{8, 16, 32, 64, 32, 32}; // Oscillator model rises every two clocks
    int chs[6] = '{10, 18, 19, 20, 21, 31};

    sarcc_top u_dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .comp_i, .rc_osc_i, .sleep_i, .pkg_large_i, .sar_code_o, .mux_sel_o,
        .mux_valid_o, .temp_sel_o, .hold_o, .conv_irq_o, .wake_o, .vector_o);

    initial forever #10 clk_i = ~clk_i;
    // Oscillator and comparator models; comparator ideal, reacts within a cycle
    always @(posedge clk_i) begin
        rc_osc_i <= ~rc_osc_i;
        comp_i <= (ain >= int'(sar_code_o));
        if (hold_o === 1'b1) hcnt++;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    // One APB transfer; waits for ready without assuming latency
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        chk(q, 32'(exp));
    endtask

    // Full conversion; power and start go in separate writes
    task conv(input int cs, input int ch, input int div);
        apb(1'b1, `SARCC_OFF_CTRL1, 32'(cs));
        apb(1'b1, `SARCC_OFF_CTRL0, 32'(ch * 4 + 1));
        repeat (20) @(posedge clk_i);
        ain = $urandom % 1024;
        hcnt = 0;
        apb(1'b1, `SARCC_OFF_CTRL0, 32'(ch * 4 + 3));
        do begin
            apb(1'b0, `SARCC_OFF_CTRL0, 32'h0);
        end while (q[1] !== 1'b0);
        res_exp = ain;
        if (div > 0) chk(32'(hcnt >= 11 * div - 3 && hcnt <= 11 * div + 3), 32'h1);
        rd(`SARCC_OFF_RESH, res_exp >> 8);
        rd(`SARCC_OFF_RESL, res_exp & 255);
    endtask

    task complete_run;
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected few thousand cycles
    initial begin
        #1500000;
        fail_count++;
        complete_run;
    end

    initial begin
        rst_i <= 1'b1;
        void'($urandom(87));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 6; a++) rd(12'(a * 4), 0);
        apb(1'b0, 12'h018, 32'h0);
        chk(32'(err), 32'h1);
        // Channel decode including the temperature tap and out-of-range codes
        foreach (chs[i]) begin
            apb(1'b1, `SARCC_OFF_CTRL0, 32'(chs[i] * 4));
            repeat (3) @(posedge clk_i);
            chk(32'(mux_sel_o), 32'(chs[i]));
            chk(32'(temp_sel_o), 32'(chs[i] == 10));
            chk(32'(mux_valid_o), 32'(chs[i] < 19));
        end
        // All six clocking select codes; flag sets with interrupt off and stays until cleared
        foreach (codes[i]) begin
            conv(codes[i], $urandom % 19, divs[i]);
            rd(`SARCC_OFF_FLAG, 1);
            chk(32'(conv_irq_o), 32'h0);
            repeat (50) @(posedge clk_i);
            rd(`SARCC_OFF_FLAG, 1);
            apb(1'b1, `SARCC_OFF_FLAG, 32'h1);
            rd(`SARCC_OFF_FLAG, 0);
        end
        // Sleep-time conversion on the oscillator clock wakes the core
        apb(1'b1, `SARCC_OFF_IEN, 32'h1);
        sleep_i <= 1'b1;
        conv(3, 10, 32);
        chk(32'(conv_irq_o), 32'h1);
        chk(32'(wake_o), 32'h1);
        chk(32'(vector_o), 32'h0);
        apb(1'b1, `SARCC_OFF_IEN, 32'h7);
        repeat (3) @(posedge clk_i);
        chk(32'(vector_o), 32'h1);
        sleep_i <= 1'b0;
        apb(1'b1, `SARCC_OFF_IEN, 32'h0);
        apb(1'b1, `SARCC_OFF_FLAG, 32'h1);
        // Software abort mid-conversion keeps the old result
        apb(1'b1, `SARCC_OFF_CTRL1, 32'h6);
        apb(1'b1, `SARCC_OFF_CTRL0, 32'h3);
        repeat (200) @(posedge clk_i);
        apb(1'b1, `SARCC_OFF_CTRL0, 32'h1);
        hcnt = 0;
        repeat (300) @(posedge clk_i);
        chk(32'(hcnt >= 120 && hcnt <= 130), 32'h1);
        rd(`SARCC_OFF_RESH, res_exp >> 8);
        rd(`SARCC_OFF_RESL, res_exp & 255);
        rd(`SARCC_OFF_FLAG, 0);
        // Sleep on a divided clock aborts, power stays on
        apb(1'b1, `SARCC_OFF_CTRL1, 32'h1);
        apb(1'b1, `SARCC_OFF_CTRL0, 32'h3);
        repeat (20) @(posedge clk_i);
        sleep_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rd(`SARCC_OFF_CTRL0, 1);
        rd(`SARCC_OFF_FLAG, 0);
        sleep_i <= 1'b0;
        // Reset in mid-conversion clears everything
        apb(1'b1, `SARCC_OFF_CTRL0, 32'h3);
        repeat (30) @(posedge clk_i);
        rst_i <= 1'b1;
        pkg_large_i <= 1'b1; // Large variant strap, held from here on
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(32'(hold_o), 32'h0);
        rd(`SARCC_OFF_CTRL0, 0);
        rd(`SARCC_OFF_RESL, 0);
        // Large variant accepts channel twenty but not twenty-one
        apb(1'b1, `SARCC_OFF_CTRL0, 32'(20 * 4));
        repeat (3) @(posedge clk_i);
        chk(32'(mux_valid_o), 32'h1);
        apb(1'b1, `SARCC_OFF_CTRL0, 32'(21 * 4));
        repeat (3) @(posedge clk_i);
        chk(32'(mux_valid_o), 32'h0);
        complete_run;
    end
endmodule
